//--- logic/gdmaba_core.sv
// dma channel bus mastership, arbitration and bus exception logic
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - serial channels outrank; grant-ack stays low
// - request bus when pending and no clear
// - arbiter raises core request, watches grants
// - wait for strobe, halt, error, ack negated
// - take bus by ack; release after transfers
// - card controller may drive bus clear
// - clear on external request or core interrupt
// - on clear finish whole operand first
// - resume exactly where transfer stopped
// - core cause: wait until pending flag clears
// - external cause: wait request negation, flag
// - recognise reset, error, halt and retry
// - chip reset aborts, clears status and mode
// - reset ends cycle, floats outputs, releases
// - software reset bit acts like chip reset but keeps pending flag and card enable
// - bus error ends cycle, logs, interrupts
// - error clears start; wait restart, negation
// - error discards held source operand
// - halt finishes cycle on ack, releases
// - halt blocks cycles; resume operand after
// - halt with error: end, release, suspend
// - after retry re-run interrupted cycle
// - error sets dest or source flag
// - start clear suspends; set resumes
module gdmaba_core
  import gdmaba_pkg::*;
#(
  parameter int OPC_W = 2
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // transfer side
  input  wire logic        i_xfer_req,
  input  wire logic        i_xfer_dest,
  input  wire logic        i_serial_dma_channels_busy,
  input  wire logic        i_core_bus_grant,
  input  wire logic        i_external_bus_request,
  input  wire logic        i_core_irq_pending,
  input  wire logic        i_card_bus_clear,
  input  wire logic        i_address_strobe_line_n,
  input  wire logic        i_halt_n,
  input  wire logic        i_bus_error_line_n,
  input  wire logic        i_bus_grant_ack_line_n,
  input  wire logic        i_transfer_ack_line_n,
  input  wire logic [15:0] i_rd_data,
  output logic             o_core_bus_request,
  output logic             o_dma_internal_bus_request,
  output logic             o_bus_grant_ack_line_n,
  output logic             o_bus_grant_ack_line_oe,
  output logic             o_address_strobe_line_n,
  output logic             o_ctrl_oe,
  output logic             o_cycle_write,
  output logic [15:0]      o_wr_data,
  output logic [1:0]       o_op_cycle,
  output logic             o_error_irq
);

  gdmaba_state_t state_q;
  logic          start_q;
  logic          errie_q;
  logic [OPC_W-1:0] opcyc_q;
  logic [OPC_W-1:0] cyc_idx_q;
  logic          dest_err_q;
  logic          src_err_q;
  logic          card_en_q;
  logic          ipa_q;
  logic          core_cause_q;
  logic          ext_cause_q;
  logic          halt_hold_q;
  logic          err_hold_q;
  logic [15:0]   data_holding_reg_q;
  logic [31:0]   done_cnt_q;
  logic          soft_rst;
  logic          bus_clear_signal;
  logic          bus_free;
  logic          may_start;
  logic          retry;
  logic          bus_error_line;
  logic          dack;
  logic          last_cyc;
  // ahb address phase capture
  logic          ph_valid_q;
  logic          ph_write_q;
  logic [7:0]    ph_addr_q;
  logic          ph_ok;
  logic          wr_mode;
  logic          wr_sys;
  logic          wr_card;
  logic          ipa_set;

  assign ph_ok   = i_hsel && i_hready && i_htrans[1];
  assign wr_mode = ph_valid_q && ph_write_q && (ph_addr_q == MODE_OFF);
  assign wr_sys  = ph_valid_q && ph_write_q && (ph_addr_q == SYSCTL_OFF);
  assign wr_card = ph_valid_q && ph_write_q && (ph_addr_q == CARD_OFF);
  assign soft_rst = wr_mode && i_hwdata[MODE_SWRST_BIT];

  // capture address phase; zero wait states
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
    end else begin
      ph_valid_q <= ph_ok;
      ph_write_q <= i_hwrite;
      ph_addr_q  <= i_haddr[7:0];
    end
  end

  // ready and okay from reset onward
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // read data registered at address phase
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (ph_ok && !i_hwrite) begin
      case (i_haddr[7:0])
        MODE_OFF: begin
          o_hrdata <= {24'h00_0000, 2'b00, opcyc_q, 1'b0, errie_q, 1'b0, start_q};
        end
        STATUS_OFF: begin
          o_hrdata <= {26'h000_0000, bus_clear_signal, halt_hold_q,
                       ~o_bus_grant_ack_line_n, (state_q != GDMABA_IDLE),
                       src_err_q, dest_err_q};
        end
        SYSCTL_OFF: o_hrdata <= {31'h0000_0000, ipa_q};
        CARD_OFF:   o_hrdata <= {31'h0000_0000, card_en_q};
        COUNT_OFF:  o_hrdata <= done_cnt_q;
        default:    o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      errie_q <= MODE_RST[MODE_ERRIE_BIT];
      opcyc_q <= '0;
    end else if (soft_rst) begin
      errie_q <= 1'b0;
      opcyc_q <= '0;
    end else if (wr_mode) begin
      errie_q <= i_hwdata[MODE_ERRIE_BIT];
      opcyc_q <= i_hwdata[MODE_OPCYC_LSB +: OPC_W];
    end
  end

  // start bit: error clears it, set wins otherwise
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_q <= MODE_RST[MODE_START_BIT];
    end else if (soft_rst || (bus_error_line && state_q == GDMABA_CYCLE && i_halt_n)) begin
      start_q <= 1'b0;
    end else if (wr_mode) begin
      start_q <= i_hwdata[MODE_START_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      card_en_q <= 1'b0;
    end else if (wr_card) begin
      card_en_q <= i_hwdata[CARD_BUS_CLEAR_SIGNAL_BIT];
    end
  end

  // pending flag: write one clears, set wins
  assign ipa_set = i_core_irq_pending;
  gdmaba_sync_flag u_ipa (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_clr (1'b0),
    .i_set      (ipa_set),
    .i_clr      (wr_sys && i_hwdata[SYS_IPA_BIT]),
    .o_flag     (ipa_q)
  );

  assign bus_clear_signal = i_external_bus_request || ipa_q ||
                            (card_en_q && i_card_bus_clear);
  // previous master fully off the bus
  assign bus_free = i_address_strobe_line_n && i_halt_n && i_bus_error_line_n &&
                    i_bus_grant_ack_line_n;
  assign may_start = start_q && i_xfer_req && !bus_clear_signal && !halt_hold_q &&
                     !err_hold_q && !core_cause_q && !ext_cause_q;
  assign bus_error_line     = !i_bus_error_line_n;
  assign retry    = bus_error_line && !i_halt_n;
  assign dack     = !i_transfer_ack_line_n;
  assign last_cyc = (cyc_idx_q == opcyc_q);

  // remember why the bus was given up
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_cause_q <= 1'b0;
      ext_cause_q  <= 1'b0;
    end else if (soft_rst) begin
      core_cause_q <= 1'b0;
      ext_cause_q  <= 1'b0;
    end else begin
      if (state_q == GDMABA_RELEASE && ipa_q) begin
        core_cause_q <= 1'b1;
      end else if (!ipa_q) begin
        core_cause_q <= 1'b0;
      end
      if (state_q == GDMABA_RELEASE && i_external_bus_request) begin
        ext_cause_q <= 1'b1;
      end else if (!i_external_bus_request) begin
        ext_cause_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_hold_q <= 1'b0;
      err_hold_q  <= 1'b0;
    end else if (soft_rst) begin
      halt_hold_q <= 1'b0;
      err_hold_q  <= 1'b0;
    end else begin
      halt_hold_q <= !i_halt_n;
      err_hold_q  <= bus_error_line;
    end
  end

  // error flags; software clears by write one
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dest_err_q <= 1'b0;
      src_err_q  <= 1'b0;
    end else if (soft_rst) begin
      // software reset clears like chip reset
      dest_err_q <= 1'b0;
      src_err_q  <= 1'b0;
    end else if (state_q == GDMABA_CYCLE && bus_error_line && i_halt_n) begin
      dest_err_q <= dest_err_q | i_xfer_dest;
      src_err_q  <= src_err_q | ~i_xfer_dest;
    end else if (ph_valid_q && ph_write_q && ph_addr_q == STATUS_OFF) begin
      dest_err_q <= dest_err_q & ~i_hwdata[STAT_DEST_BIT];
      src_err_q  <= src_err_q & ~i_hwdata[STAT_SRC_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_error_irq <= 1'b0;
    end else begin
      o_error_irq <= errie_q && (dest_err_q || src_err_q);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_holding_reg_q <= 16'h0000;
    end else if (soft_rst || (state_q == GDMABA_CYCLE && bus_error_line && i_halt_n)) begin
      data_holding_reg_q <= 16'h0000;
    end else if (state_q == GDMABA_CYCLE && dack && !i_xfer_dest) begin
      data_holding_reg_q <= i_rd_data;
    end
  end

  // completed operand counter
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_cnt_q <= COUNT_RST;
    end else if (soft_rst) begin
      done_cnt_q <= COUNT_RST;
    end else if (state_q == GDMABA_CYCLE && dack && !bus_error_line && last_cyc) begin
      done_cnt_q <= done_cnt_q + 32'h0000_0001;
    end
  end

  // sequencer handles reset, error, halt, retry
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q   <= GDMABA_IDLE;
      cyc_idx_q <= '0;
    end else if (soft_rst) begin
      // abort at once and drop the bus
      state_q   <= GDMABA_IDLE;
      cyc_idx_q <= '0;
    end else begin
      case (state_q)
        GDMABA_IDLE: begin
          if (may_start) begin
            state_q <= GDMABA_REQ;
          end
        end
        GDMABA_REQ: begin
          // grant from core and no external request
          if (!may_start) begin
            state_q <= GDMABA_IDLE;
          end else if (i_core_bus_grant && !i_external_bus_request) begin
            state_q <= GDMABA_WAIT_FREE;
          end
        end
        GDMABA_WAIT_FREE: begin
          if (bus_free) begin
            state_q <= GDMABA_CYCLE;
          end
        end
        GDMABA_CYCLE: begin
          if (retry) begin
            // keep index so the cycle reruns
            state_q <= GDMABA_RELEASE;
          end else if (bus_error_line) begin
            state_q   <= GDMABA_RELEASE;
            cyc_idx_q <= '0;
          end else if (dack) begin
            if (!last_cyc) begin
              cyc_idx_q <= cyc_idx_q + 1'b1;
              state_q   <= i_halt_n ? GDMABA_NEXT : GDMABA_RELEASE;
            end else begin
              cyc_idx_q <= '0;
              state_q   <= GDMABA_NEXT;
            end
          end
        end
        GDMABA_NEXT: begin
          // serial channels may slip in; ack stays low
          if (!i_halt_n) begin
            state_q <= GDMABA_RELEASE;
          end else if (cyc_idx_q != '0) begin
            if (!i_serial_dma_channels_busy) begin
              state_q <= GDMABA_CYCLE;
            end
          end else if (may_start) begin
            if (!i_serial_dma_channels_busy) begin
              state_q <= GDMABA_CYCLE;
            end
          end else begin
            state_q <= GDMABA_RELEASE;
          end
        end
        GDMABA_RELEASE: begin
          state_q <= GDMABA_IDLE;
        end
        default: state_q <= GDMABA_IDLE;
      endcase
    end
  end

  // resume interrupted operand from idle
  // (idle with nonzero index re-requests via may_start)

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_grant_ack_line_n  <= 1'b1;
      o_bus_grant_ack_line_oe <= 1'b0;
      o_address_strobe_line_n <= 1'b1;
      o_ctrl_oe               <= 1'b0;
      o_cycle_write           <= 1'b0;
      o_wr_data               <= 16'h0000;
      o_op_cycle              <= 2'b00;
    end else begin
      o_bus_grant_ack_line_n  <= !(state_q == GDMABA_CYCLE || state_q == GDMABA_NEXT) ||
                                 soft_rst;
      o_bus_grant_ack_line_oe <= (state_q == GDMABA_CYCLE || state_q == GDMABA_NEXT) &&
                                 !soft_rst;
      o_address_strobe_line_n <= !(state_q == GDMABA_CYCLE && !dack && !bus_error_line) || soft_rst;
      o_ctrl_oe               <= state_q == GDMABA_CYCLE && !soft_rst;
      o_cycle_write           <= i_xfer_dest;
      o_wr_data               <= data_holding_reg_q;
      o_op_cycle              <= 2'(cyc_idx_q);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_internal_bus_request <= 1'b0;
      o_core_bus_request         <= 1'b0;
    end else begin
      o_dma_internal_bus_request <= state_q == GDMABA_REQ && may_start;
      o_core_bus_request         <= state_q == GDMABA_REQ && may_start;
    end
  end

endmodule : gdmaba_core

//--- logic/gdmaba_pkg.sv
// shared constants for the dma bus arbitration and exception block
package gdmaba_pkg;
  // register byte offsets
  localparam logic [7:0] MODE_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] SYSCTL_OFF = 8'h08;
  localparam logic [7:0] CARD_OFF   = 8'h0c;
  localparam logic [7:0] COUNT_OFF  = 8'h10;
  // mode register fields
  localparam int MODE_START_BIT = 0;
  localparam int MODE_SWRST_BIT = 1;
  localparam int MODE_ERRIE_BIT = 2;
  localparam int MODE_OPCYC_LSB = 4;
  // status register fields
  localparam int STAT_DEST_BIT  = 0;
  localparam int STAT_SRC_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 2;
  localparam int STAT_OWN_BIT   = 3;
  localparam int STAT_HALT_BIT  = 4;
  localparam int STAT_BUS_CLEAR_SIGNAL_BIT  = 5;
  // system control and card config fields
  localparam int SYS_IPA_BIT    = 0;
  localparam int CARD_BUS_CLEAR_SIGNAL_BIT  = 0;
  // reset values
  localparam logic [31:0] MODE_RST  = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  // most bus cycles per operand transfer
  localparam int MAX_OP_CYCLES = 4;
  localparam int BUS_CYC_CLKS  = 1;
  typedef enum logic [2:0] {
    GDMABA_IDLE, GDMABA_REQ, GDMABA_WAIT_FREE, GDMABA_CYCLE, GDMABA_NEXT, GDMABA_RELEASE
  } gdmaba_state_t;
endpackage : gdmaba_pkg

//--- logic/gdmaba_sync_flag.sv
// sticky flag cell: hardware set wins over software clear
`timescale 1ns/1ps
module gdmaba_sync_flag (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_soft_clr,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);
  // set has priority over clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr || i_soft_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule : gdmaba_sync_flag

//--- verification/dma_bus_arbitration_exceptions_tb.sv
// bench for the dma bus arbitration and exception block
`timescale 1ns/1ps
module dma_bus_arbitration_exceptions_tb;
  import gdmaba_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        xreq = 1'b0;
  logic        xdst = 1'b0;
  logic        sbusy = 1'b0;
  logic        ereq = 1'b0;
  logic        irq = 1'b0;
  logic        cclr = 1'b0;
  logic        hreq = 1'b0;
  logic [1:0]  mode = 2'd0;
  logic [3:0]  dly = 4'd1;
  logic [31:0] hrdata, q, c0;
  logic        hrdy, hresp, creq, ireq, bgn, bgoe, asn, coe, cwr, eirq;
  logic        grant, ackn, berrn, haltn, as_w, bg_w;
  logic [15:0] wdat, rd;
  logic [1:0]  opc;
  int          failures = 0;
  int          comparisons = 0;
  int          ncyc = 0;
  int          c, d, op, k, n;
  // shared wires with pull-ups
  assign as_w = coe ? asn : 1'b1;
  assign bg_w = bgoe ? bgn : 1'b1;
  always #20 clk = ~clk;
  always @(posedge clk) sbusy <= ($urandom % 8) == 0;
  always @(negedge as_w) if (rst_n) ncyc++;
  gdmaba_core u_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_xfer_req(xreq), .i_xfer_dest(xdst), .i_serial_dma_channels_busy(sbusy),
    .i_core_bus_grant(grant), .i_external_bus_request(ereq), .i_core_irq_pending(irq),
    .i_card_bus_clear(cclr), .i_address_strobe_line_n(as_w), .i_halt_n(haltn),
    .i_bus_error_line_n(berrn), .i_bus_grant_ack_line_n(bg_w),
    .i_transfer_ack_line_n(ackn), .i_rd_data(rd), .o_core_bus_request(creq),
    .o_dma_internal_bus_request(ireq), .o_bus_grant_ack_line_n(bgn),
    .o_bus_grant_ack_line_oe(bgoe), .o_address_strobe_line_n(asn), .o_ctrl_oe(coe),
    .o_cycle_write(cwr), .o_wr_data(wdat), .o_op_cycle(opc), .o_error_irq(eirq));
  gdmaba_bus_peer u_peer (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_as_n(as_w), .i_core_req(creq),
    .i_halt_req(hreq), .i_mode(mode), .i_dly(dly), .o_grant(grant),
    .o_ack_n(ackn), .o_bus_error_line_n(berrn), .o_halt_n(haltn), .o_rd(rd));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo;
    chk(32'hdead, 32'h0);
    report_and_stop();
  endtask : tmo
  task automatic tick(input int t);
    repeat (t) @(posedge clk);
  endtask : tick
  task automatic wrdy;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hrdy !== 1'b1 && i < 64);
    if (i >= 64) tmo();
  endtask : wrdy
  // one single word transfer, read data taken at data phase end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dv,
                     output logic [31:0] rv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dv;
    wrdy();
    rv = hrdata;
  endtask : acc
  task automatic wcyc(input int t);
    int i;
    for (i = 0; i < 3000 && ncyc < t; i++) @(posedge clk);
    if (ncyc < t) tmo();
  endtask : wcyc
  task automatic widle;
    int i;
    tick(3);
    for (i = 0; i < 3000 && bgn !== 1'b1; i++) @(posedge clk);
    if (bgn !== 1'b1) tmo();
  endtask : widle
  function automatic logic [31:0] mval(input int o, input logic ie);
    return (32'(o) << MODE_OPCYC_LSB) | (32'(ie) << MODE_ERRIE_BIT) | 32'h1;
  endfunction : mval
  initial begin
    void'($urandom(67789));
    tick(10);
    rst_n <= 1'b1;
    tick(2);
    acc(1'b1, 8'h40, 32'hffff_ffff, q);
    acc(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    acc(1'b0, MODE_OFF, 32'h0, q);
    chk(q, MODE_RST);
    acc(1'b0, COUNT_OFF, 32'h0, q);
    chk(q, COUNT_RST);
    $display("reset value test done");
    for (c = 0; c < 4; c++) begin
      op = $urandom % 4;
      k = 1 + $urandom % 3;
      dly <= (c == 3) ? 4'd6 : 4'($urandom % 3);
      acc(1'b0, COUNT_OFF, 32'h0, c0);
      acc(1'b1, MODE_OFF, mval(op, 1'b0), q);
      ncyc = 0;
      xreq <= 1'b1;
      wcyc((k - 1) * (op + 1) + 1);
      xreq <= 1'b0;
      widle();
      chk(32'(ncyc), 32'(k * (op + 1)));
      acc(1'b0, COUNT_OFF, 32'h0, q);
      chk(q - c0, 32'(k));
    end
    $display("transfer test done");
    for (c = 0; c < 5; c++) begin
      op = $urandom % 4;
      acc(1'b1, CARD_OFF, 32'(c == 1), q);
      acc(1'b1, MODE_OFF, mval(op, 1'b0), q);
      ncyc = 0;
      xreq <= 1'b1;
      wcyc(2);
      ereq <= (c == 0);
      cclr <= (c == 1);
      irq <= (c == 2);
      hreq <= (c == 3);
      if (c == 4) acc(1'b1, MODE_OFF, mval(op, 1'b0) & ~32'h1, q);
      widle();
      n = ncyc;
      if (c != 3) chk(32'(n % (op + 1)), 32'h0);
      chk(32'(opc), 32'(n % (op + 1)));
      tick(40);
      chk(32'(ncyc), 32'(n));
      ereq <= 1'b0;
      cclr <= 1'b0;
      irq <= 1'b0;
      hreq <= 1'b0;
      if (c == 2) begin
        tick(20);
        chk(32'(ncyc), 32'(n));
        acc(1'b1, SYSCTL_OFF, 32'h1, q);
      end
      if (c == 4) acc(1'b1, MODE_OFF, mval(op, 1'b0), q);
      wcyc(n + 1);
      xreq <= 1'b0;
      widle();
    end
    $display("bus clear test done");
    for (d = 0; d < 2; d++) begin
      acc(1'b1, MODE_OFF, mval(1, d[0]), q);
      xdst <= d[0];
      mode <= 2'd1;
      ncyc = 0;
      xreq <= 1'b1;
      wcyc(1);
      tick(2);
      mode <= 2'd0;
      widle();
      tick(30);
      chk(32'(ncyc), 32'h1);
      chk(32'(eirq), 32'(d));
      acc(1'b0, STATUS_OFF, 32'h0, q);
      chk(q & 32'h3, d ? 32'h1 : 32'h2);
      chk(32'(cwr), 32'(d));
      chk(32'(wdat), 32'h0);
      acc(1'b0, MODE_OFF, 32'h0, q);
      chk(q & 32'h1, 32'h0);
      xreq <= 1'b0;
      acc(1'b1, STATUS_OFF, 32'h3, q);
    end
    $display("bus error test done");
    acc(1'b1, MODE_OFF, mval(1, 1'b0), q);
    mode <= 2'd2;
    ncyc = 0;
    xreq <= 1'b1;
    wcyc(1);
    tick(2);
    mode <= 2'd0;
    wcyc(2);
    xreq <= 1'b0;
    widle();
    chk(32'(ncyc), 32'h3);
    acc(1'b0, STATUS_OFF, 32'h0, q);
    chk(q & 32'h3, 32'h0);
    $display("retry test done");
    acc(1'b1, MODE_OFF, mval(3, 1'b1), q);
    acc(1'b1, MODE_OFF, 32'h2, q);
    acc(1'b0, MODE_OFF, 32'h0, q);
    chk(q, 32'h0);
    acc(1'b1, MODE_OFF, mval(3, 1'b0), q);
    dly <= 4'd6;
    xreq <= 1'b1;
    wcyc(ncyc + 1);
    rst_n <= 1'b0;
    tick(2);
    chk({30'h0, bgoe, coe}, 32'h0);
    rst_n <= 1'b1;
    xreq <= 1'b0;
    tick(2);
    acc(1'b0, MODE_OFF, 32'h0, q);
    chk(q, 32'h0);
    acc(1'b0, STATUS_OFF, 32'h0, q);
    chk(q, 32'h0);
    $display("reset test done");
    report_and_stop();
  end
endmodule : dma_bus_arbitration_exceptions_tb
bind gdmaba_core gdmaba_core_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_core_bus_request(o_core_bus_request),
  .o_dma_internal_bus_request(o_dma_internal_bus_request),
  .o_bus_grant_ack_line_n(o_bus_grant_ack_line_n),
  .o_bus_grant_ack_line_oe(o_bus_grant_ack_line_oe),
  .o_address_strobe_line_n(o_address_strobe_line_n), .o_ctrl_oe(o_ctrl_oe),
  .i_halt_n(i_halt_n), .i_bus_error_line_n(i_bus_error_line_n),
  .i_bus_grant_ack_line_n(i_bus_grant_ack_line_n),
  .i_transfer_ack_line_n(i_transfer_ack_line_n));

//--- verification/gdmaba_bus_peer.sv
// arbiter and far-side slave model
`timescale 1ns/1ps
module gdmaba_bus_peer (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_as_n,
  input  wire logic       i_core_req,
  input  wire logic       i_halt_req,
  input  wire logic [1:0] i_mode,
  input  wire logic [3:0] i_dly,
  output logic            o_grant,
  output logic            o_ack_n,
  output logic            o_bus_error_line_n,
  output logic            o_halt_n,
  output logic [15:0]     o_rd
);
  logic       on_q;
  logic       done_q;
  logic       rty_q;
  logic [1:0] m_q;
  logic [3:0] cnt_q;
  // halt from bench or retry answer
  assign o_halt_n = !(i_halt_req || rty_q);
  // answer after delay, negate once strobe rises
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_grant <= 1'b0;
      o_ack_n <= 1'b1;
      o_bus_error_line_n <= 1'b1;
      o_rd <= 16'h0;
      on_q <= 1'b0;
      done_q <= 1'b0;
      rty_q <= 1'b0;
      m_q <= 2'd0;
      cnt_q <= 4'd0;
    end else begin
      o_grant <= i_core_req;
      if (!i_as_n && !on_q && !done_q) begin
        on_q <= 1'b1;
        cnt_q <= i_dly;
        m_q <= i_mode;
      end else if (on_q && cnt_q != 4'd0) begin
        cnt_q <= cnt_q - 4'd1;
      end else if (on_q) begin
        on_q <= 1'b0;
        done_q <= 1'b1;
        o_ack_n <= (m_q != 2'd0);
        o_bus_error_line_n <= (m_q == 2'd0);
        rty_q <= (m_q == 2'd2);
        o_rd <= o_rd + 16'h1357;
      end
      if (done_q && i_as_n) begin
        done_q <= 1'b0;
        o_ack_n <= 1'b1;
        o_bus_error_line_n <= 1'b1;
        rty_q <= 1'b0;
        o_rd <= ~o_rd;
      end
    end
  end
endmodule : gdmaba_bus_peer

//--- verification/gdmaba_core_assertions.sv
// port checker for the dma bus arbitration block
`timescale 1ns/1ps
module gdmaba_core_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_core_bus_request,
  input wire logic o_dma_internal_bus_request,
  input wire logic o_bus_grant_ack_line_n,
  input wire logic o_bus_grant_ack_line_oe,
  input wire logic o_address_strobe_line_n,
  input wire logic o_ctrl_oe,
  input wire logic i_halt_n,
  input wire logic i_bus_error_line_n,
  input wire logic i_bus_grant_ack_line_n,
  input wire logic i_transfer_ack_line_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  AST_BUS_OKAY:
    assert property (o_hreadyout && !o_hresp) else $error("slave not zero-wait okay");
  AST_CORE_REQ:
    assert property (o_core_bus_request == o_dma_internal_bus_request)
    else $error("core request not following channel request");
  AST_TAKE_FREE:
    assert property ($fell(o_bus_grant_ack_line_n)
      |-> $past(i_bus_grant_ack_line_n && i_halt_n && i_bus_error_line_n, 2))
    else $error("grant ack taken while bus owned");
  AST_NO_START:
    assert property ($fell(o_address_strobe_line_n) |-> $past(i_halt_n && i_bus_error_line_n))
    else $error("cycle started under halt or error");
  AST_STROBE_OWN:
    assert property (!o_address_strobe_line_n [*2] |-> !o_bus_grant_ack_line_n)
    else $error("strobe without grant ack");
  AST_RELEASE_IDLE:
    assert property ($rose(o_bus_grant_ack_line_n) |-> o_address_strobe_line_n)
    else $error("bus released mid cycle");
  AST_ACK_END:
    assert property ($rose(o_address_strobe_line_n)
      |-> $past(!i_transfer_ack_line_n || !i_bus_error_line_n))
    else $error("cycle ended without ack or error");
  AST_RESET_FLOAT:
    assert property ($rose(i_rst_n)
      |-> o_bus_grant_ack_line_n && !o_bus_grant_ack_line_oe && !o_ctrl_oe)
    else $error("outputs driven after reset");
endmodule : gdmaba_core_chk
